// ---- logic/cpg_pkg.sv ----
package cpg_pkg;
  // register offsets (byte addresses, one aligned word each)
  localparam logic [3:0] SYS_CLK_CTRL_OFS   = 4'h0;
  localparam logic [3:0] LOW_PWR_CTRL_OFS   = 4'h4;
  localparam logic [3:0] SLEEP_CMD_OFS      = 4'h8;
  localparam logic [3:0] MODE_STATUS_OFS    = 4'hC;
  // reset values
  localparam logic [7:0] SYS_CLK_CTRL_RST   = 8'h00;
  localparam logic [7:0] LOW_PWR_CTRL_RST   = 8'h00;
  // low_power_clock_control field positions
  localparam int DIRECT_TRANSITION_BIT      = 7;
  localparam int LOW_SPEED_BIT              = 6;
  localparam int NOISE_RATE_BIT             = 5;
  localparam int SUBCLOCK_DISABLE_BIT       = 4;
  localparam int FEEDBACK_BYPASS_BIT        = 3;
  localparam int PLL_MULT_LSB               = 0;
  // system_clock_control_reg field positions
  localparam int BUS_CLOCK_SELECT_LSB       = 0;
  // sleep command register field positions
  localparam int STANDBY_SELECT_BIT         = 0;
  localparam int PRESCALER_SELECT_BIT       = 1;
  localparam int WAKE_BIT                   = 2;
  // noise sampling divisions
  localparam logic [4:0] NOISE_DIV_SLOW     = 5'h1F;
  localparam logic [4:0] NOISE_DIV_FAST     = 5'h03;
  // duty adjustment threshold
  localparam int DUTY_ADJ_MIN_KHZ           = 5000;
  localparam int SYS_CLK_KHZ                = 10000;
  // pll multiplier codes
  localparam logic [1:0] PLL_TIMES_ONE      = 2'h0;
  localparam logic [1:0] PLL_BYPASS         = 2'h3;
  // usb pll factors
  localparam logic [1:0] USB_MUL_16MHZ      = 2'h3;
  localparam logic [1:0] USB_MUL_24MHZ      = 2'h2;

  typedef enum logic [2:0] {
    CPG_HIGH_SPEED = 3'h0,
    CPG_MEDIUM     = 3'h1,
    CPG_SLEEP      = 3'h2,
    CPG_STANDBY    = 3'h3,
    CPG_WATCH      = 3'h4,
    CPG_SUBACTIVE  = 3'h5,
    CPG_SUBSLEEP   = 3'h6
  } cpg_mode_e;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] sel;
    logic [3:0] adr;
    logic [31:0] dat;
  } cpg_wb_req_s;

  typedef struct packed {
    logic [1:0] pll_mult;
    logic       feedback_bypass;
    logic       pll_prohibited;
  } cpg_osc_cfg_s;
endpackage

// ---- logic/cpg_ctrl.sv ----
// The implementer's own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
// Overview of operation
// - bus clock select 000 full speed, 001..101 divide by 2..32, 11X prohibited
// - direct flag 0: sleep leads to sleep, standby or watch; subactive to subsleep/watch
// - direct flag 1 in high/medium speed: direct to subactive, else sleep or standby
// - direct flag 1 in subactive: direct to high speed, else subsleep
// - low speed 0: subactive sleep goes watch or high speed; watch wakes high speed
// - low speed 1: high speed to watch/subactive; watch wakes in subactive
// - subclock sampled at system clock over 32 or over 4 per noise select
// - subclock generated while disable bit is 0, stopped when 1
// - feedback bypass bit takes effect only on entering software standby
// - pll field 00 times one, 01/10 prohibited, 11 bypass; applied on standby
// - duty adjustment active when oscillator runs at or above 5 MHz and the latched feedback bypass is 0
// - medium speed divider makes system clock over 2, 4, 8, 16, 32
// - no subclock sampling in subactive, subsleep or watch mode
// - usb pll multiplies 16 MHz by three or 24 MHz by two to 48 MHz
module cpg_ctrl (
  input  wire logic               sys_clk,
  input  wire logic               arst_n,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [3:0]         wb_adr_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               sleep_req,
  input  wire logic               wake_req,
  input  wire logic               subclk_pin,
  input  wire logic               main_24mhz,
  output logic                    bus_clk_en,
  output logic                    subclk_out,
  output logic                    subclk_run,
  output logic                    duty_adj_on,
  output cpg_pkg::cpg_osc_cfg_s   osc_cfg,
  output logic      [1:0]         usb_pll_mul,
  output cpg_pkg::cpg_mode_e      mode
);
  logic [1:0]  rst_sync_reg;
  logic        rst_n;
  logic [7:0]  sck_reg;
  logic [7:0]  lpw_reg;
  logic [2:0]  sby_reg;
  logic [2:0]  sck_act_reg;
  logic [4:0]  div_reg;
  logic [4:0]  noise_cnt_reg;
  logic [2:0]  sub_sync_reg;
  logic [1:0]  sleep_sync_reg;
  logic [1:0]  wake_sync_reg;
  logic [1:0]  main_sync_reg;
  logic        sleep_d_reg;
  logic        wake_d_reg;
  logic        sleep_pulse;
  logic        wake_pulse;
  logic        access;
  logic        direct_transition_flag;
  logic        low_speed_flag;
  logic        ssby;
  logic        pss;
  logic        no_sample;
  cpg_pkg::cpg_mode_e mode_reg;
  cpg_pkg::cpg_mode_e mode_next;

  function automatic logic div_tick(input logic [2:0] sel, input logic [4:0] cnt);
    case (sel)
      3'h0:    div_tick = 1'b1;
      3'h1:    div_tick = cnt[0] == 1'b1;
      3'h2:    div_tick = cnt[1:0] == 2'h3;
      3'h3:    div_tick = cnt[2:0] == 3'h7;
      3'h4:    div_tick = cnt[3:0] == 4'hF;
      3'h5:    div_tick = cnt == 5'h1F;
      default: div_tick = 1'b1;
    endcase
  endfunction

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // wishbone slave: registered ack after one wait state, ack drops after one cycle
  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      if (access && !wb_we_i) begin
        case (wb_adr_i)
          cpg_pkg::SYS_CLK_CTRL_OFS: wb_dat_o <= {24'h000000, sck_reg};
          cpg_pkg::LOW_PWR_CTRL_OFS: wb_dat_o <= {24'h000000, lpw_reg};
          cpg_pkg::SLEEP_CMD_OFS:    wb_dat_o <= {29'h0000000, sby_reg};
          cpg_pkg::MODE_STATUS_OFS:  wb_dat_o <= {29'h0000000, mode_reg};
          default:                   wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_reg <= cpg_pkg::SYS_CLK_CTRL_RST;
      lpw_reg <= cpg_pkg::LOW_PWR_CTRL_RST;
      sby_reg <= 3'h0;
    end else if (access && wb_we_i && wb_sel_i[0]) begin
      case (wb_adr_i)
        cpg_pkg::SYS_CLK_CTRL_OFS: sck_reg <= {wb_dat_i[7:6], 2'h0, wb_dat_i[3:0]};
        cpg_pkg::LOW_PWR_CTRL_OFS: lpw_reg <= wb_dat_i[7:0];
        cpg_pkg::SLEEP_CMD_OFS:    sby_reg <= wb_dat_i[2:0];
        default: ;
      endcase
    end
  end

  assign direct_transition_flag = lpw_reg[cpg_pkg::DIRECT_TRANSITION_BIT];
  assign low_speed_flag = lpw_reg[cpg_pkg::LOW_SPEED_BIT];
  assign ssby = sby_reg[cpg_pkg::STANDBY_SELECT_BIT];
  assign pss  = sby_reg[cpg_pkg::PRESCALER_SELECT_BIT];

  // pin-side requests synchronised, then edge detected from the second stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_sync_reg <= 2'h0;
      wake_sync_reg  <= 2'h0;
      main_sync_reg  <= 2'h0;
      sleep_d_reg    <= 1'b0;
      wake_d_reg     <= 1'b0;
    end else begin
      sleep_sync_reg <= {sleep_sync_reg[0], sleep_req};
      wake_sync_reg  <= {wake_sync_reg[0], wake_req};
      // strap pin is asynchronous too
      main_sync_reg  <= {main_sync_reg[0], main_24mhz};
      sleep_d_reg    <= sleep_sync_reg[1];
      wake_d_reg     <= wake_sync_reg[1];
    end
  end
  assign sleep_pulse = sleep_sync_reg[1] && !sleep_d_reg;
  assign wake_pulse  = wake_sync_reg[1] && !wake_d_reg;

  // mode transitions; illegal combinations hold the current mode
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      cpg_pkg::CPG_HIGH_SPEED, cpg_pkg::CPG_MEDIUM: begin
        if (sleep_pulse) begin
          if (!ssby && !low_speed_flag) begin
            mode_next = cpg_pkg::CPG_SLEEP;
          end else if (ssby && !pss && !low_speed_flag) begin
            mode_next = cpg_pkg::CPG_STANDBY;
          end else if (ssby && pss && !direct_transition_flag) begin
            mode_next = cpg_pkg::CPG_WATCH;
          end else if (ssby && pss && low_speed_flag && direct_transition_flag) begin
            mode_next = cpg_pkg::CPG_SUBACTIVE;
          end
        end else if (sck_act_reg != 3'h0) begin
          mode_next = cpg_pkg::CPG_MEDIUM;
        end else begin
          mode_next = cpg_pkg::CPG_HIGH_SPEED;
        end
      end
      cpg_pkg::CPG_SUBACTIVE: begin
        if (sleep_pulse) begin
          if (!ssby && pss && low_speed_flag) begin
            mode_next = cpg_pkg::CPG_SUBSLEEP;
          end else if (ssby && pss && !direct_transition_flag) begin
            mode_next = cpg_pkg::CPG_WATCH;
          end else if (ssby && pss && !low_speed_flag && direct_transition_flag) begin
            mode_next = cpg_pkg::CPG_HIGH_SPEED;
          end
        end
      end
      cpg_pkg::CPG_WATCH: begin
        if (wake_pulse) begin
          mode_next = low_speed_flag ? cpg_pkg::CPG_SUBACTIVE : cpg_pkg::CPG_HIGH_SPEED;
        end
      end
      cpg_pkg::CPG_SUBSLEEP: begin
        if (wake_pulse) begin
          mode_next = cpg_pkg::CPG_SUBACTIVE;
        end
      end
      cpg_pkg::CPG_SLEEP, cpg_pkg::CPG_STANDBY: begin
        if (wake_pulse) begin
          mode_next = cpg_pkg::CPG_HIGH_SPEED;
        end
      end
      default: mode_next = cpg_pkg::CPG_HIGH_SPEED;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= cpg_pkg::CPG_HIGH_SPEED;
    end else begin
      mode_reg <= mode_next;
    end
  end
  assign mode = mode_reg;

  // oscillator settings latch only on entry to software standby
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cfg <= '0;
    end else if (mode_next == cpg_pkg::CPG_STANDBY && mode_reg != cpg_pkg::CPG_STANDBY) begin
      osc_cfg.feedback_bypass <= lpw_reg[cpg_pkg::FEEDBACK_BYPASS_BIT];
      osc_cfg.pll_mult        <= lpw_reg[cpg_pkg::PLL_MULT_LSB +: 2];
      osc_cfg.pll_prohibited  <= lpw_reg[1:0] != cpg_pkg::PLL_TIMES_ONE
                                 && lpw_reg[1:0] != cpg_pkg::PLL_BYPASS;
    end
  end

  // free divider; selection swaps only when the count wraps
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg     <= 5'h00;
      sck_act_reg <= 3'h0;
    end else begin
      div_reg <= div_reg + 5'h01;
      if (div_reg == 5'h1F && sck_reg[2:1] != 2'h3) begin
        sck_act_reg <= sck_reg[cpg_pkg::BUS_CLOCK_SELECT_LSB +: 3];
      end
    end
  end
  // prohibited codes never reach the active select
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_clk_en <= 1'b1;
    end else begin
      bus_clk_en <= div_tick(sck_act_reg, div_reg);
    end
  end

  // subclock noise filter: three-stage sampler at the selected rate
  assign no_sample = mode_reg == cpg_pkg::CPG_SUBACTIVE || mode_reg == cpg_pkg::CPG_SUBSLEEP
                     || mode_reg == cpg_pkg::CPG_WATCH;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      noise_cnt_reg <= 5'h00;
      sub_sync_reg  <= 3'h0;
      subclk_out    <= 1'b0;
    end else begin
      sub_sync_reg <= {sub_sync_reg[1:0], subclk_pin};
      if (lpw_reg[cpg_pkg::SUBCLOCK_DISABLE_BIT]) begin
        subclk_out    <= 1'b0;
        noise_cnt_reg <= 5'h00;
      end else if (no_sample) begin
        subclk_out <= sub_sync_reg[1];
      end else if (noise_cnt_reg == 5'h00) begin
        noise_cnt_reg <= lpw_reg[cpg_pkg::NOISE_RATE_BIT] ? cpg_pkg::NOISE_DIV_FAST
                                                           : cpg_pkg::NOISE_DIV_SLOW;
        if (sub_sync_reg[2] == sub_sync_reg[1]) begin
          subclk_out <= sub_sync_reg[1];
        end
      end else begin
        noise_cnt_reg <= noise_cnt_reg - 5'h01;
      end
    end
  end
  assign subclk_run  = !lpw_reg[cpg_pkg::SUBCLOCK_DISABLE_BIT];
  // fixed system clock rate is above the threshold, bypass disables it
  assign duty_adj_on = (cpg_pkg::SYS_CLK_KHZ >= cpg_pkg::DUTY_ADJ_MIN_KHZ)
                       && !osc_cfg.feedback_bypass;
  assign usb_pll_mul = main_sync_reg[1] ? cpg_pkg::USB_MUL_24MHZ
                                        : cpg_pkg::USB_MUL_16MHZ;

  a_bus_div_change: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(sck_act_reg) |-> $past(div_reg) == 5'h1F)
    else $error("bus divide changed off boundary");
  a_no_prohibited: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sck_act_reg[2:1] != 2'h3)
    else $error("prohibited bus select active");
  a_full_speed: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sck_act_reg == 3'h0 |=> bus_clk_en)
    else $error("full speed clock gated");
  a_watch_wake: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode_reg == cpg_pkg::CPG_WATCH && wake_pulse |=>
      mode_reg == ($past(low_speed_flag) ? cpg_pkg::CPG_SUBACTIVE : cpg_pkg::CPG_HIGH_SPEED))
    else $error("watch wake target wrong");
  a_direct_sub: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode_reg == cpg_pkg::CPG_HIGH_SPEED && sleep_pulse && ssby && pss && low_speed_flag && direct_transition_flag
      |=> mode_reg == cpg_pkg::CPG_SUBACTIVE)
    else $error("direct transition to subactive missed");
  a_direct_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode_reg == cpg_pkg::CPG_SUBACTIVE && sleep_pulse && ssby && pss && !low_speed_flag && direct_transition_flag
      |=> mode_reg == cpg_pkg::CPG_HIGH_SPEED)
    else $error("direct transition to high speed missed");
  a_sleep_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode_reg == cpg_pkg::CPG_HIGH_SPEED && sleep_pulse && !ssby && !low_speed_flag
      |=> mode_reg == cpg_pkg::CPG_SLEEP)
    else $error("sleep entry missed");
  a_osc_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode_reg != cpg_pkg::CPG_STANDBY ##1 mode_reg != cpg_pkg::CPG_STANDBY
      |-> $stable(osc_cfg))
    else $error("oscillator config changed outside standby entry");
  a_sub_stop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    lpw_reg[cpg_pkg::SUBCLOCK_DISABLE_BIT] |=> !subclk_out)
    else $error("subclock runs while disabled");
  a_noise_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    no_sample && !lpw_reg[cpg_pkg::SUBCLOCK_DISABLE_BIT]
      |=> noise_cnt_reg == $past(noise_cnt_reg))
    else $error("sampling while in sub modes");

  c_enter_watch: cover property (@(posedge sys_clk) mode_reg == cpg_pkg::CPG_WATCH);
  c_enter_sub: cover property (@(posedge sys_clk) mode_reg == cpg_pkg::CPG_SUBACTIVE);
  c_div32: cover property (@(posedge sys_clk) sck_act_reg == 3'h5);
  c_standby: cover property (@(posedge sys_clk) mode_reg == cpg_pkg::CPG_STANDBY);
endmodule

// ---- verification/tb_clock_pulse_generator_ctrl.sv ----
`timescale 1ns/1ps
module tb_clock_pulse_generator_ctrl;
  logic                  sys_clk;
  logic                  arst_n;
  logic                  wb_cyc_i;
  logic                  wb_stb_i;
  logic                  wb_we_i;
  logic [3:0]            wb_sel_i;
  logic [3:0]            wb_adr_i;
  logic [31:0]           wb_dat_i;
  logic [31:0]           wb_dat_o;
  logic                  wb_ack_o;
  logic                  sleep_req;
  logic                  wake_req;
  logic                  subclk_pin;
  logic                  main_24mhz;
  logic                  bus_clk_en;
  logic                  subclk_out;
  logic                  subclk_run;
  logic                  duty_adj_on;
  cpg_pkg::cpg_osc_cfg_s osc_cfg;
  logic [1:0]            usb_pll_mul;
  cpg_pkg::cpg_mode_e    mode;
  int                    fail_count;
  int                    cmp_count;

  cpg_ctrl u_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_req(sleep_req), .wake_req(wake_req),
    .subclk_pin(subclk_pin), .main_24mhz(main_24mhz), .bus_clk_en(bus_clk_en),
    .subclk_out(subclk_out), .subclk_run(subclk_run), .duty_adj_on(duty_adj_on),
    .osc_cfg(osc_cfg), .usb_pll_mul(usb_pll_mul), .mode(mode)
  );

  always #50 sys_clk = ~sys_clk;

  task automatic end_of_test;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // one classic cycle; entered just after a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_sel_i <= 4'h1;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    if (n >= 50) fail_count++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(exp, q);
  endtask

  // sleep (s=1) or wake (s=0) strobe, then judge the mode
  task automatic ev(input logic s, input cpg_pkg::cpg_mode_e m);
    if (s) sleep_req <= 1'b1;
    else wake_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sleep_req <= 1'b0;
    wake_req  <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(32'(m), 32'(mode));
  endtask

  task automatic sl(input logic [7:0] lp, input logic [1:0] cmd, input cpg_pkg::cpg_mode_e m);
    wr(cpg_pkg::LOW_PWR_CTRL_OFS, lp);
    wr(cpg_pkg::SLEEP_CMD_OFS, {6'h00, cmd});
    ev(1'b1, m);
  endtask

  task automatic reg_test;
    rdc(cpg_pkg::SYS_CLK_CTRL_OFS, 32'h0);
    rdc(cpg_pkg::LOW_PWR_CTRL_OFS, 32'h0);
    chk(32'h0, 32'(osc_cfg.pll_mult));
    wr(cpg_pkg::SYS_CLK_CTRL_OFS, 8'hF0);
    rdc(cpg_pkg::SYS_CLK_CTRL_OFS, 32'hC0);
    wr(cpg_pkg::SYS_CLK_CTRL_OFS, 8'h00);
    wr(cpg_pkg::LOW_PWR_CTRL_OFS, 8'h04);
    rdc(cpg_pkg::LOW_PWR_CTRL_OFS, 32'h04);
    rdc(4'h2, 32'h0);
  endtask

  // pulse spacing for every legal select code; a prohibited code keeps divide by 32
  task automatic div_test;
    int n;
    for (int c = 0; c < 7; c++) begin
      wr(cpg_pkg::SYS_CLK_CTRL_OFS, 8'(c == 6 ? 7 : c));
      repeat (70) @(posedge sys_clk);
      chk(32'(c == 0 ? cpg_pkg::CPG_HIGH_SPEED : cpg_pkg::CPG_MEDIUM), 32'(mode));
      n = 0;
      while (bus_clk_en !== 1'b1 && n < 100) begin
        @(posedge sys_clk);
        n++;
      end
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (bus_clk_en !== 1'b1 && n < 100);
      chk(32'(1 << (c == 6 ? 5 : c)), 32'(n));
    end
    wr(cpg_pkg::SYS_CLK_CTRL_OFS, 8'h00);
  endtask

  task automatic misc_test;
    wr(cpg_pkg::LOW_PWR_CTRL_OFS, 8'h23);
    chk(32'h1, 32'(subclk_run));
    subclk_pin <= 1'b1;
    repeat (30) @(posedge sys_clk);
    chk(32'h1, 32'(subclk_out));
    wr(cpg_pkg::LOW_PWR_CTRL_OFS, 8'h03);
    subclk_pin <= 1'b0;
    repeat (100) @(posedge sys_clk);
    chk(32'h0, 32'(subclk_out));
    wr(cpg_pkg::LOW_PWR_CTRL_OFS, 8'h13);
    chk(32'h0, 32'(subclk_run));
    subclk_pin <= 1'b1;
    repeat (40) @(posedge sys_clk);
    chk(32'h0, 32'(subclk_out));
    subclk_pin <= 1'b0;
    main_24mhz <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(32'h2, 32'(usb_pll_mul));
    main_24mhz <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(32'h3, 32'(usb_pll_mul));
  endtask

  task automatic mode_test;
    sl(8'h03, 2'h0, cpg_pkg::CPG_SLEEP);
    ev(1'b0, cpg_pkg::CPG_HIGH_SPEED);
    chk(32'h1, 32'(duty_adj_on));
    wr(cpg_pkg::LOW_PWR_CTRL_OFS, 8'h08);
    chk(32'h0, 32'(osc_cfg.pll_mult));
    sl(8'h0B, 2'h1, cpg_pkg::CPG_STANDBY);
    chk(32'hE, 32'(osc_cfg));
    chk(32'h0, 32'(duty_adj_on));
    ev(1'b0, cpg_pkg::CPG_HIGH_SPEED);
    sl(8'h09, 2'h1, cpg_pkg::CPG_STANDBY);
    chk(32'h7, 32'(osc_cfg));
    ev(1'b0, cpg_pkg::CPG_HIGH_SPEED);
    sl(8'h03, 2'h3, cpg_pkg::CPG_WATCH);
    ev(1'b0, cpg_pkg::CPG_HIGH_SPEED);
    sl(8'h43, 2'h3, cpg_pkg::CPG_WATCH);
    ev(1'b0, cpg_pkg::CPG_SUBACTIVE);
    subclk_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(32'h1, 32'(subclk_out));
    sl(8'h43, 2'h2, cpg_pkg::CPG_SUBSLEEP);
    ev(1'b0, cpg_pkg::CPG_SUBACTIVE);
    sl(8'h83, 2'h3, cpg_pkg::CPG_HIGH_SPEED);
    sl(8'hC3, 2'h3, cpg_pkg::CPG_SUBACTIVE);
    sl(8'h03, 2'h3, cpg_pkg::CPG_WATCH);
    ev(1'b0, cpg_pkg::CPG_HIGH_SPEED);
    rdc(cpg_pkg::MODE_STATUS_OFS, 32'h0);
  endtask

  initial begin
    sys_clk    = 1'b0;
    arst_n     = 1'b0;
    wb_cyc_i   = 1'b0;
    wb_stb_i   = 1'b0;
    wb_we_i    = 1'b0;
    wb_sel_i   = 4'h0;
    wb_adr_i   = 4'h0;
    wb_dat_i   = 32'h0;
    sleep_req  = 1'b0;
    wake_req   = 1'b0;
    subclk_pin = 1'b0;
    main_24mhz = 1'b0;
    fail_count = 0;
    cmp_count  = 0;
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reg_test;
    div_test;
    misc_test;
    mode_test;
    end_of_test;
  end

  // whole run needs about 1100 cycles; eighteen times that is a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    end_of_test;
  end
endmodule
